// ---- system_clock_ratio_control.sv ----
// Purpose: Clock ratio decode, pin clock division and per-unit clock enables
// Assumes: All derived clocks are modelled as enables on sys_clk
// Notes:   Reset word is taken from straps or a hard option when the power-on reset pin releases
`timescale 1ns/1ps

// Behaviour
// - Outside host mode, platform bus multiplier is (1 + input divide config) times system PLL multiplier.
// - In host mode the scaled reference equals the primary clock input.
// - Platform clock feeds the core; core PLL ratio is passed out.
// - PLL multipliers come from reset word loaded at power-on or hard option.
// - Memory clock is half the platform clock times one plus memory ratio bit.
// - Memory pin clock is memory clock divided by two.
// - Local bus unit clock is half the platform clock times one plus its ratio bit.
// - Local bus pin clocks divide local unit clock by twice the divider field (field 0 acts as 1).
// - Configurable units reset to platform clock divided by three.
// - Units choose off, full, half or third of platform clock.
// - PCI and DMA complex run full rate by default, or off.
// - PCI input clock is dedicated pin or reference depending on host mode.
module system_clock_ratio_control
(
	input  wire logic                              sys_clk,
	input  wire logic                              sys_rst,
	input  wire logic                              powerOnResetPin_n,
	input  wire logic [clock_ratio_pkg::CFG_W-1:0] strapCfg,
	input  wire logic [1:0]                        hardOptionSel,
	input  wire logic                              req64Pin_n,
	input  wire logic                              pciClockPin,
	input  wire logic                              pciReferencePin,
	input  wire logic                              inputClockDivideCfg,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [7:0]                        paddr,
	input  wire logic [31:0]                       pwdata,
	output logic [31:0]                            prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	output clock_ratio_pkg::ratio_cfg_t            ratioCfg,
	output logic [5:0]                             platformMultiplier,
	output logic                                   pciInputClock,
	output logic                                   req64Sampled,
	output logic                                   memoryClockEn,
	output logic                                   memoryBusClockOut,
	output logic                                   localBusClockEn,
	output logic                                   localBusClockOutput,
	output logic                                   localBusSyncOutput,
	output logic [clock_ratio_pkg::NUM_UNITS-1:0]  unitClockEn
);

	// ==========================================================
	// Power-on reset pin synchroniser (three stages)
	logic [2:0] porSync_reg;
	logic       porStable_reg;
	wire        porAgree = porSync_reg[1] == porSync_reg[2];

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			porSync_reg   <= 3'h0;
			porStable_reg <= 1'b0;
		end
		else
		begin
			porSync_reg <= {porSync_reg[1:0], powerOnResetPin_n};
			if (porAgree)
				porStable_reg <= porSync_reg[2];
		end
	end

	// Request-64 strap synchroniser
	logic [2:0] reqSync_reg;
	logic       reqStable_reg;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			reqSync_reg   <= 3'h7;
			reqStable_reg <= 1'b1;
		end
		else
		begin
			reqSync_reg <= {reqSync_reg[1:0], req64Pin_n};
			if (reqSync_reg[1] == reqSync_reg[2])
				reqStable_reg <= reqSync_reg[2];
		end
	end

	// ==========================================================
	// Reset word capture sequence
	clock_ratio_pkg::por_state_t porState_reg;
	clock_ratio_pkg::por_state_t porState_next;
	logic [clock_ratio_pkg::CFG_W-1:0] resetCfg_reg;
	logic [clock_ratio_pkg::CFG_W-1:0] resetCfg_next;
	logic                              req64_reg;
	logic                              req64_next;
	wire [clock_ratio_pkg::CFG_W-1:0]  selectedCfg;

	// Straps or a hard-coded option
	assign selectedCfg = (hardOptionSel == 2'h1) ? clock_ratio_pkg::HARD_OPT0 :
		(hardOptionSel == 2'h2) ? clock_ratio_pkg::HARD_OPT1 : strapCfg;

	always_comb
	begin
		porState_next = porState_reg;
		resetCfg_next = resetCfg_reg;
		req64_next    = req64_reg;
		case (porState_reg)
			clock_ratio_pkg::POR_HOLD:
				if (porStable_reg)
					porState_next = clock_ratio_pkg::POR_SAMPLE;
			clock_ratio_pkg::POR_SAMPLE:
			begin
				resetCfg_next = selectedCfg;
				req64_next    = ~reqStable_reg;
				porState_next = clock_ratio_pkg::POR_RUN;
			end
			clock_ratio_pkg::POR_RUN:
				if (!porStable_reg)
					porState_next = clock_ratio_pkg::POR_HOLD;
			default:
				porState_next = clock_ratio_pkg::POR_HOLD;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			porState_reg <= clock_ratio_pkg::POR_HOLD;
			resetCfg_reg <= clock_ratio_pkg::HARD_OPT0;
			req64_reg    <= 1'b0;
		end
		else
		begin
			porState_reg <= porState_next;
			resetCfg_reg <= resetCfg_next;
			req64_reg    <= req64_next;
		end
	end

	// ==========================================================
	// Ratio decode from the reset word
	wire running = porState_reg == clock_ratio_pkg::POR_RUN;

	always_comb
	begin
		ratioCfg.systemPllMultiplier =
			resetCfg_reg[clock_ratio_pkg::SYSMUL_LSB +: clock_ratio_pkg::SYSMUL_W];
		ratioCfg.cpuPllRatio =
			resetCfg_reg[clock_ratio_pkg::CPU_LSB +: clock_ratio_pkg::CPU_W];
		ratioCfg.memoryClockRatioBit   = resetCfg_reg[clock_ratio_pkg::MEMBIT_POS];
		ratioCfg.localBusClockRatioBit = resetCfg_reg[clock_ratio_pkg::LBBIT_POS];
		ratioCfg.pciHostMode           = resetCfg_reg[clock_ratio_pkg::HOST_POS];
	end

	// Platform multiplier relative to reference; host mode uses primary input
	wire [5:0] sysMulWide = {2'h0, ratioCfg.systemPllMultiplier};
	assign platformMultiplier = (ratioCfg.pciHostMode || !inputClockDivideCfg) ?
		sysMulWide : 6'(sysMulWide << 1);

	// PCI input clock source select
	assign pciInputClock = ratioCfg.pciHostMode ? pciReferencePin : pciClockPin;
	assign req64Sampled  = req64_reg;

	// ==========================================================
	// Memory and local bus clock enables, platform clock is sys_clk
	logic phase_reg;
	logic memPin_reg;
	logic [clock_ratio_pkg::LDIV_W-1:0] ldivCnt_reg;
	logic [clock_ratio_pkg::LDIV_W-1:0] ldivField_reg;
	logic lbPin_reg;
	logic lbSync_reg;

	// Ratio bit set: double rate; clear: one enable per two platform clocks
	assign memoryClockEn   = ratioCfg.memoryClockRatioBit | phase_reg;
	assign localBusClockEn = ratioCfg.localBusClockRatioBit | phase_reg;
	assign memoryBusClockOut   = memPin_reg;
	assign localBusClockOutput = lbPin_reg;
	assign localBusSyncOutput  = lbSync_reg;

	wire [clock_ratio_pkg::LDIV_W-1:0] ldivLast = (ldivField_reg == 3'h0) ?
		3'h0 : 3'(ldivField_reg - 3'h1);
	wire ldivWrap = ldivCnt_reg >= ldivLast;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			phase_reg   <= 1'b0;
			memPin_reg  <= 1'b0;
			ldivCnt_reg <= 3'h0;
			lbPin_reg   <= 1'b0;
			lbSync_reg  <= 1'b0;
		end
		else if (!running)
		begin
			phase_reg   <= 1'b0;
			ldivCnt_reg <= 3'h0;
		end
		else
		begin
			phase_reg <= ~phase_reg;
			if (memoryClockEn)
				memPin_reg <= ~memPin_reg;
			if (localBusClockEn)
			begin
				ldivCnt_reg <= ldivWrap ? 3'h0 : 3'(ldivCnt_reg + 3'h1);
				if (ldivWrap)
				begin
					lbPin_reg  <= ~lbPin_reg;
					lbSync_reg <= ~lbPin_reg;
				end
			end
		end
	end

	// ==========================================================
	// Per-unit clock selection and enables
	logic [1:0] unitSel_reg [clock_ratio_pkg::NUM_UNITS];
	logic [1:0] unitActive_reg [clock_ratio_pkg::NUM_UNITS];
	logic [1:0] div3Cnt_reg;
	logic       div2Cnt_reg;
	wire        div3Tick = div3Cnt_reg == 2'h0;
	wire        div3Wrap = div3Cnt_reg == clock_ratio_pkg::DIV3_LAST;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			div3Cnt_reg <= 2'h0;
			div2Cnt_reg <= 1'b0;
		end
		else
		begin
			div3Cnt_reg <= div3Wrap ? 2'h0 : 2'(div3Cnt_reg + 2'h1);
			div2Cnt_reg <= ~div2Cnt_reg;
		end
	end

	genvar u;
	generate
		for (u = 0; u < clock_ratio_pkg::NUM_UNITS; u++)
		begin : g_unit
			// Ratio swaps only when both dividers are at phase zero
			wire boundary = div3Tick && !div2Cnt_reg;
			always_ff @(posedge sys_clk)
			begin
				if (sys_rst)
					unitActive_reg[u] <= (u == clock_ratio_pkg::PCI_UNIT) ?
						clock_ratio_pkg::UNIT_FULL : clock_ratio_pkg::UNIT_DIV3;
				else if (boundary)
					unitActive_reg[u] <= unitSel_reg[u];
			end
			always_comb
			begin
				case (unitActive_reg[u])
					clock_ratio_pkg::UNIT_OFF:  unitClockEn[u] = 1'b0;
					clock_ratio_pkg::UNIT_FULL: unitClockEn[u] = 1'b1;
					clock_ratio_pkg::UNIT_DIV2: unitClockEn[u] = !div2Cnt_reg;
					clock_ratio_pkg::UNIT_DIV3: unitClockEn[u] = div3Tick;
					default:                    unitClockEn[u] = 1'b0;
				endcase
			end
		end
	endgenerate

	// ==========================================================
	// APB slave: zero wait states, error on unmapped address
	wire setup     = psel && !penable;
	wire access    = psel && penable;
	wire hitReset  = paddr == clock_ratio_pkg::OFF_RESET_CFG;
	wire hitLocal  = paddr == clock_ratio_pkg::OFF_LOCAL_CTRL;
	wire hitUnit   = paddr == clock_ratio_pkg::OFF_UNIT_RATIO;
	wire hitStat   = paddr == clock_ratio_pkg::OFF_MODE_STAT;
	wire mapped    = hitReset || hitLocal || hitUnit || hitStat;
	wire writeDone = access && pwrite && mapped;

	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	logic [31:0] readMux;
	logic [31:0] prdata_reg;
	logic [13:0] unitPacked;

	always_comb
	begin
		for (int i = 0; i < clock_ratio_pkg::NUM_UNITS; i++)
			unitPacked[2*i +: 2] = unitActive_reg[i];
		readMux = 32'h0;
		if (hitReset)
			readMux = {21'h0, resetCfg_reg};
		else if (hitLocal)
			readMux = {29'h0, ldivField_reg};
		else if (hitUnit)
			readMux = {18'h0, unitPacked};
		else if (hitStat)
			readMux = {28'h0, req64_reg, ratioCfg.pciHostMode, porState_reg};
	end

	assign prdata = prdata_reg;

	// Read data latched in setup so it is held through the access phase
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			prdata_reg <= 32'h0;
		else if (setup)
			prdata_reg <= readMux;
	end

	// Writable divider field and unit selections
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			ldivField_reg <= clock_ratio_pkg::LDIV_RESET;
			for (int i = 0; i < clock_ratio_pkg::NUM_UNITS; i++)
				unitSel_reg[i] <= (i == clock_ratio_pkg::PCI_UNIT) ?
					clock_ratio_pkg::UNIT_FULL : clock_ratio_pkg::UNIT_DIV3;
		end
		else if (writeDone && hitLocal)
			ldivField_reg <= pwdata[clock_ratio_pkg::LDIV_W-1:0];
		else if (writeDone && hitUnit)
		begin
			for (int i = 0; i < clock_ratio_pkg::NUM_UNITS; i++)
				if (i == clock_ratio_pkg::PCI_UNIT)
					unitSel_reg[i] <= pwdata[2*i] ? clock_ratio_pkg::UNIT_FULL :
						clock_ratio_pkg::UNIT_OFF;
				else
					unitSel_reg[i] <= pwdata[2*i +: 2];
		end
	end

endmodule

// ---- clock_ratio_pkg.sv ----
// Purpose: Shared constants and types for the system clock ratio control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Offsets, fields and reset values are named here only
package clock_ratio_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] OFF_RESET_CFG  = 8'h00;
	localparam logic [7:0] OFF_LOCAL_CTRL = 8'h04;
	localparam logic [7:0] OFF_UNIT_RATIO = 8'h08;
	localparam logic [7:0] OFF_MODE_STAT  = 8'h0c;

	// ==========================================================
	// Reset configuration word low field layout
	localparam int SYSMUL_LSB  = 0;
	localparam int SYSMUL_W    = 4;
	localparam int CPU_LSB     = 4;
	localparam int CPU_W       = 3;
	localparam int MEMBIT_POS  = 7;
	localparam int LBBIT_POS   = 8;
	localparam int DIVCFG_POS  = 9;
	localparam int HOST_POS    = 10;
	localparam int CFG_W       = 11;

	// Local bus divider field width and reset value
	localparam int LDIV_W = 3;
	localparam logic [LDIV_W-1:0] LDIV_RESET = 3'h2;

	// ==========================================================
	// Unit clock selections
	typedef enum logic [1:0]
	{
		UNIT_OFF  = 2'h0,
		UNIT_FULL = 2'h1,
		UNIT_DIV2 = 2'h2,
		UNIT_DIV3 = 2'h3
	} unit_sel_t;

	// Units: 0..5 with four options, 6 is the PCI/DMA complex
	localparam int NUM_UNITS = 7;
	localparam int PCI_UNIT  = 6;
	localparam logic [1:0] DIV3_LAST = 2'h2;

	// Reset option strap settings, selectable at power-on
	localparam logic [CFG_W-1:0] HARD_OPT0 = 11'h014;
	localparam logic [CFG_W-1:0] HARD_OPT1 = 11'h423;

	// Power-on sampling sequence states, Gray coded from hold to run; run back to hold flips both bits
	typedef enum logic [1:0]
	{
		POR_HOLD   = 2'b00,
		POR_SAMPLE = 2'b01,
		POR_RUN    = 2'b11
	} por_state_t;

	// Clock ratio results carried together
	typedef struct packed
	{
		logic [SYSMUL_W-1:0] systemPllMultiplier;
		logic [CPU_W-1:0]  cpuPllRatio;
		logic              memoryClockRatioBit;
		logic              localBusClockRatioBit;
		logic              pciHostMode;
	} ratio_cfg_t;

endpackage

// ---- clock_ratio_checker.sv ----
// Purpose: Port-level properties of the clock ratio block
// Assumes: One clock domain, synchronous reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps

module clock_ratio_checker
(
	input wire logic                                 sys_clk,
	input wire logic                                 sys_rst,
	input wire logic                                 inputClockDivideCfg,
	input wire logic                                 pciClockPin,
	input wire logic                                 pciReferencePin,
	input wire clock_ratio_pkg::ratio_cfg_t          ratioCfg,
	input wire logic [5:0]                           platformMultiplier,
	input wire logic                                 pciInputClock,
	input wire logic                                 memoryClockEn,
	input wire logic                                 memoryBusClockOut,
	input wire logic                                 localBusClockEn,
	input wire logic                                 localBusClockOutput,
	input wire logic [clock_ratio_pkg::NUM_UNITS-1:0] unitClockEn
);
	// Multiplier widened for the doubling case
	wire logic [5:0] sysMul6 = {2'h0, ratioCfg.systemPllMultiplier};

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// Ratio decode and clock selection
	AST_PLAT_MULT: assert property (platformMultiplier == (ratioCfg.pciHostMode ? sysMul6 :
		(inputClockDivideCfg ? sysMul6 << 1 : sysMul6))) else $error("platform multiplier wrong");
	AST_PCI_SEL: assert property (pciInputClock ==
		(ratioCfg.pciHostMode ? pciReferencePin : pciClockPin)) else $error("pci clock source wrong");
	AST_RESET_DEFAULT: assert property ($fell(sys_rst) |->
		unitClockEn[clock_ratio_pkg::PCI_UNIT] && {ratioCfg.pciHostMode,
		ratioCfg.localBusClockRatioBit, ratioCfg.memoryClockRatioBit, ratioCfg.cpuPllRatio,
		ratioCfg.systemPllMultiplier} == {clock_ratio_pkg::HARD_OPT0[10],
		clock_ratio_pkg::HARD_OPT0[8:0]})
		else $error("reset defaults wrong");

	// ==========================================================
	// Memory and local bus enables and pin clocks
	AST_MEM_FULL: assert property (ratioCfg.memoryClockRatioBit |-> memoryClockEn)
		else $error("memory enable missing at double rate");
	AST_MEM_HALF: assert property ((!ratioCfg.memoryClockRatioBit && memoryClockEn) ##1
		!ratioCfg.memoryClockRatioBit |-> !memoryClockEn) else $error("memory enable too fast");
	AST_MEM_PIN: assert property ($changed(memoryBusClockOut) |-> $past(memoryClockEn))
		else $error("memory pin clock moved without enable");
	AST_LB_FULL: assert property (ratioCfg.localBusClockRatioBit |-> localBusClockEn)
		else $error("local bus enable missing at double rate");
	AST_LB_PIN: assert property ($changed(localBusClockOutput) |-> $past(localBusClockEn))
		else $error("local pin clock moved without enable");
endmodule

bind system_clock_ratio_control clock_ratio_checker i_clock_ratio_checker
(
	.sys_clk(sys_clk), .sys_rst(sys_rst), .inputClockDivideCfg(inputClockDivideCfg),
	.pciClockPin(pciClockPin), .pciReferencePin(pciReferencePin), .ratioCfg(ratioCfg),
	.platformMultiplier(platformMultiplier), .pciInputClock(pciInputClock),
	.memoryClockEn(memoryClockEn), .memoryBusClockOut(memoryBusClockOut),
	.localBusClockEn(localBusClockEn), .localBusClockOutput(localBusClockOutput),
	.unitClockEn(unitClockEn)
);

// ---- board_clock_model.sv ----
// Purpose: Board clock source and power-on strap logic
// Assumes: Straps and REQ64 are driven from the start of each power-on pulse
// Notes:   Straps are inverted later so a late capture shows up
`timescale 1ns/1ps

module board_clock_model
(
	input  wire logic        sys_clk,
	input  wire logic        startPor,
	input  wire logic [10:0] strapValue,
	input  wire logic        req64Value,
	output logic             powerOnResetPin_n,
	output logic [10:0]      strapCfg,
	output logic             req64Pin_n,
	output logic             pciClockPin,
	output logic             pciReferencePin
);
	logic [3:0] holdCount;
	logic [1:0] edgeCount;

	initial
	begin
		powerOnResetPin_n = 1'b0;
		strapCfg = 11'h0;
		req64Pin_n = 1'b1;
		holdCount = 4'hf;
		edgeCount = 2'h0;
	end

	// Power-on pulse, straps valid well before release
	always @(posedge sys_clk)
	begin
		edgeCount <= edgeCount + 2'h1;
		if (startPor)
		begin
			powerOnResetPin_n <= 1'b0;
			strapCfg <= strapValue;
			req64Pin_n <= req64Value;
			holdCount <= 4'h0;
		end
		else if (holdCount != 4'hf)
		begin
			holdCount <= holdCount + 4'h1;
			if (holdCount == 4'h5)
				powerOnResetPin_n <= 1'b1;
			if (holdCount == 4'he)
			begin
				strapCfg <= ~strapCfg;
				req64Pin_n <= ~req64Pin_n;
			end
		end
	end

	// Two free-running PCI clocks of different rate
	assign pciReferencePin = edgeCount[0];
	assign pciClockPin = edgeCount[1];
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the clock ratio block
// Assumes: APB answers with pready; straps from the board model
// Notes:   Read results go through a queue checked by a monitor
`timescale 1ns/1ps

module tb_top;
	logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, startPor;
	logic        inputClockDivideCfg, req64Value, req64Sampled, powerOnResetPin_n, req64Pin_n;
	logic        pciClockPin, pciReferencePin, pciInputClock, memoryClockEn, memoryBusClockOut;
	logic        localBusClockEn, localBusClockOutput, localBusSyncOutput;
	logic [1:0]  hardOptionSel;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, word;
	logic [5:0]  platformMultiplier;
	logic [10:0] strapCfg, strapValue, expWord;
	logic [6:0]  unitClockEn;
	logic [8:0]  probe;
	logic [32:0] expQ[$];
	clock_ratio_pkg::ratio_cfg_t ratioCfg;
	int          fails, checks, opt, d, u, n, seed;

	system_clock_ratio_control i_system_clock_ratio_control
	(
		.sys_clk(sys_clk), .sys_rst(sys_rst), .powerOnResetPin_n(powerOnResetPin_n),
		.strapCfg(strapCfg), .hardOptionSel(hardOptionSel), .req64Pin_n(req64Pin_n),
		.pciClockPin(pciClockPin), .pciReferencePin(pciReferencePin),
		.inputClockDivideCfg(inputClockDivideCfg), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ratioCfg(ratioCfg), .platformMultiplier(platformMultiplier),
		.pciInputClock(pciInputClock), .req64Sampled(req64Sampled),
		.memoryClockEn(memoryClockEn), .memoryBusClockOut(memoryBusClockOut),
		.localBusClockEn(localBusClockEn), .localBusClockOutput(localBusClockOutput),
		.localBusSyncOutput(localBusSyncOutput), .unitClockEn(unitClockEn)
	);

	board_clock_model i_board_clock_model
	(
		.sys_clk(sys_clk), .startPor(startPor), .strapValue(strapValue),
		.req64Value(req64Value), .powerOnResetPin_n(powerOnResetPin_n), .strapCfg(strapCfg),
		.req64Pin_n(req64Pin_n), .pciClockPin(pciClockPin), .pciReferencePin(pciReferencePin)
	);

	assign probe = {localBusClockOutput, memoryBusClockOut, unitClockEn};
	always #25 sys_clk = ~sys_clk;

	// ==========================================================
	// Comparison, verdict and bus tasks
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp)
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		if (got !== exp)
			fails++;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v,
		input logic [32:0] exp);
		expQ.push_back(exp);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= v;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (n = 0; n < 1 || (pready !== 1'b1 && n < 20); n++)
			@(posedge sys_clk);
		if (n == 20)
			fails++;
		if (n == 20)
			tally_and_finish();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Count highs of a unit enable, or changes of a pin clock
	task automatic measure(input int idx, input int exp);
		logic last;
		int cnt;
		cnt = 0;
		@(negedge sys_clk);
		last = probe[idx];
		repeat (24)
		begin
			@(negedge sys_clk);
			cnt += (idx < 7) ? int'(probe[idx]) : int'(probe[idx] != last);
			last = probe[idx];
		end
		check(33'(cnt), 33'(exp));
		@(posedge sys_clk);
	endtask

	// Monitor takes the oldest note at each completed access
	always @(posedge sys_clk)
		if (psel && penable && pready)
			check({pslverr, pwrite ? 32'h0 : prdata}, expQ.pop_front());

	// ==========================================================
	// Main sequence
	initial
	begin
		seed = 32'h6cedee83;
		{sys_clk, psel, penable, pwrite, paddr, pwdata, hardOptionSel} = '0;
		{inputClockDivideCfg, req64Value, strapValue, fails, checks} = '0;
		sys_rst = 1'b1;
		startPor = 1'b1;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		startPor <= 1'b0;
		apb(1'b0, clock_ratio_pkg::OFF_UNIT_RATIO, 32'h0, 33'h1fff);
		apb(1'b0, clock_ratio_pkg::OFF_LOCAL_CTRL, 32'h0, 33'h2);
		apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
		for (opt = 0; opt < 4; opt++)
		begin
			word = $random(seed);
			expWord = (opt == 1) ? clock_ratio_pkg::HARD_OPT0 :
				(opt == 2) ? clock_ratio_pkg::HARD_OPT1 : word[10:0];
			hardOptionSel <= opt[1:0];
			strapValue <= word[10:0];
			req64Value <= word[11];
			inputClockDivideCfg <= word[12];
			startPor <= 1'b1;
			@(posedge sys_clk);
			startPor <= 1'b0;
			@(posedge sys_clk);
			for (n = 0; n < 40 && strapCfg === strapValue; n++)
				@(posedge sys_clk);
			if (n == 40)
				fails++;
			if (n == 40)
				tally_and_finish();
			apb(1'b1, clock_ratio_pkg::OFF_RESET_CFG, 32'hffffffff, 33'h0);
			apb(1'b0, clock_ratio_pkg::OFF_RESET_CFG, 32'h0, {22'h0, expWord});
			apb(1'b0, clock_ratio_pkg::OFF_MODE_STAT, 32'h0,
				{29'h0, !word[11], expWord[clock_ratio_pkg::HOST_POS], 2'h3});
			check(33'(req64Sampled), 33'(!word[11]));
			check({23'h0, ratioCfg.pciHostMode, ratioCfg.localBusClockRatioBit,
				ratioCfg.memoryClockRatioBit, ratioCfg.cpuPllRatio, ratioCfg.systemPllMultiplier},
				{23'h0, expWord[10], expWord[8:0]});
			measure(7, expWord[clock_ratio_pkg::MEMBIT_POS] ? 24 : 12);
			for (d = 0; d < 5; d++)
			begin
				apb(1'b1, clock_ratio_pkg::OFF_LOCAL_CTRL, 32'(d), 33'h0);
				repeat (24) @(posedge sys_clk);
				measure(8, (expWord[clock_ratio_pkg::LBBIT_POS] ? 24 : 12) / (d ? d : 1));
				check(33'(localBusSyncOutput), 33'(localBusClockOutput));
			end
			word = $random(seed);
			apb(1'b1, clock_ratio_pkg::OFF_UNIT_RATIO, word, 33'h0);
			repeat (8) @(posedge sys_clk);
			apb(1'b0, clock_ratio_pkg::OFF_UNIT_RATIO, 32'h0, {1'b0, word & 32'h1fff});
			for (u = 0; u < 7; u++)
				measure(u, (u == 6) ? (word[12] ? 24 : 0) :
					(word[2*u+:2] ? 24 / int'(word[2*u+:2]) : 0));
		end
		tally_and_finish();
	end
endmodule
